// ---- rtl/ssdl_loader.sv ----
`timescale 1ns/1ns
`default_nettype none

// Contract
// - eee strap sets port 1 mac default
// - port 1 eee strap ignored on fiber
// - eee strap sets three phy a bits
// - crossover strap defaults 1, sets status bit
// - strap select uses both crossover straps
// - manual strap low straight, high crossed
// - phy straps except duplex ignored while phy on fiber
// - negotiation strap defaults 1, sets enable
// - negotiation strap shapes adverts, mode
// - speed strap shapes rate, adverts, mode
// - duplex strap shapes duplex, 10fd, mode
module ssdl_loader (
    input wire logic clk,
    input wire logic rst_n,
    // strap levels, held stable around reset release
    input wire logic port1_low_power_ether_strap,
    input wire logic phy_b_auto_crossover_strap,
    input wire logic phy_b_manual_crossover_strap,
    input wire logic phy_b_negotiation_strap,
    input wire logic phy_b_rate_strap,
    input wire logic phy_b_duplex_strap,
    input wire logic phy_a_fiber_mode,
    input wire logic phy_b_fiber_mode,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // configuration handed to the port logic
    output logic mac_tx_low_power_enable,
    output logic phy_low_power_enable,
    output logic phy_negotiation_enable,
    output logic phy_rate_select_lsb,
    output logic mode_bit_a,
    output logic phy_b_auto_crossover,
    output logic phy_b_crossed,
    output logic load_done
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // byte lane enables spread to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    // one writable bit: takes bus data when its lane is written
    function automatic logic wr_bit(
        input logic old,
        input logic hit,
        input logic [31:0] mask,
        input logic [31:0] data,
        input int unsigned pos
    );
        wr_bit = (hit && mask[pos]) ? data[pos] : old;
    endfunction : wr_bit

    // ------------------------------------------------------------
    // state and register declarations
    // ------------------------------------------------------------
    ssdl_pkg::ssdl_state_type state_ff; // loader sequencing
    ssdl_pkg::ssdl_state_type nxt_state;
    logic mac_eee_ff; // mac transmit low power enable
    logic phy_a_eee_ff; // phy a low power enable
    logic phy_a_cap_ff; // phy a 100tx eee capability, read only
    logic phy_a_adv_ff; // phy a 100tx eee advert
    logic xover_state_ff; // crossover strap state, read only
    logic man_xover_ff; // sampled manual crossover strap
    logic xsel_ff; // crossover control select
    logic xauto_ff; // register auto crossover enable
    logic xman_ff; // register manual crossed selection
    logic an_ff; // phy b negotiation enable
    logic rate_ff; // phy b rate select lsb
    logic dup_ff; // phy b duplex mode
    logic adv_10fd_ff; // phy b 10base-t full duplex advert
    logic adv_10hd_ff; // phy b 10base-t half duplex advert
    logic [2:0] mode_ff; // phy b mode field
    logic [7:0] strap_raw_ff; // raw strap snapshot for debug
    logic ack_ff; // wishbone acknowledge
    logic [31:0] dat_ff; // wishbone read data
    logic xover_auto_ff; // registered crossover outputs
    logic xover_cross_ff;

    // decoded defaults from the strap decoder
    logic mac_eee_dflt;
    logic phy_a_eee_dflt;
    logic auto_xover_dflt;
    logic man_xover_dflt;
    logic an_dflt;
    logic rate_dflt;
    logic dup_dflt;
    logic adv_10fd_dflt;
    logic adv_10hd_dflt;
    logic [2:0] mode_dflt;

    // bus decode
    logic loading; // defaults being loaded this cycle
    logic access; // new bus cycle accepted this edge
    logic wr_en; // accepted write
    logic [31:0] wmask; // byte lane mask of the write
    logic [31:0] rd_word; // read mux result
    logic nxt_cross; // crossover decision
    logic nxt_auto;

    // ------------------------------------------------------------
    // strap decoding
    // ------------------------------------------------------------
    ssdl_strap_decode u_decode (
        .eee_strap(port1_low_power_ether_strap),
        .auto_xover_strap(phy_b_auto_crossover_strap),
        .man_xover_strap(phy_b_manual_crossover_strap),
        .an_strap(phy_b_negotiation_strap),
        .speed_strap(phy_b_rate_strap),
        .duplex_strap(phy_b_duplex_strap),
        .phy_a_fiber(phy_a_fiber_mode),
        .phy_b_fiber(phy_b_fiber_mode),
        .mac_eee_dflt(mac_eee_dflt),
        .phy_a_eee_dflt(phy_a_eee_dflt),
        .auto_xover_dflt(auto_xover_dflt),
        .man_xover_dflt(man_xover_dflt),
        .an_dflt(an_dflt),
        .rate_dflt(rate_dflt),
        .dup_dflt(dup_dflt),
        .adv_10fd_dflt(adv_10fd_dflt),
        .adv_10hd_dflt(adv_10hd_dflt),
        .mode_dflt(mode_dflt)
    );

    // ------------------------------------------------------------
    // loader sequencing
    // ------------------------------------------------------------

    // straps are caught on the first edge after release, never
    // under the asynchronous reset itself
    always_comb begin
        case (state_ff)
            ssdl_pkg::SSDL_LOAD: nxt_state = ssdl_pkg::SSDL_RUN;
            ssdl_pkg::SSDL_RUN: nxt_state = ssdl_pkg::SSDL_RUN;
            default: nxt_state = ssdl_pkg::SSDL_LOAD;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ssdl_pkg::SSDL_LOAD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign loading = (state_ff == ssdl_pkg::SSDL_LOAD);

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------

    // bus is held off while loading so a write cannot race the load
    assign access = wb_cyc_i && wb_stb_i && !ack_ff &&
                    (state_ff == ssdl_pkg::SSDL_RUN);
    assign wr_en = access && wb_we_i;
    assign wmask = lane_mask(wb_sel_i);

    // one wait state, ack drops the cycle after it is given
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= access;
        end
    end

    // read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rd_word = ssdl_pkg::RD_ZERO;
        case (wb_adr_i)
            ssdl_pkg::ADDR_MAC_TX_CFG: begin
                rd_word[ssdl_pkg::POS_MAC_EEE] = mac_eee_ff;
            end
            ssdl_pkg::ADDR_PHYA_EDPD: begin
                rd_word[ssdl_pkg::POS_PHY_EEE] = phy_a_eee_ff;
            end
            ssdl_pkg::ADDR_PHYA_CAP: begin
                rd_word[ssdl_pkg::POS_EEE_100TX] = phy_a_cap_ff;
            end
            ssdl_pkg::ADDR_PHYA_ADV: begin
                rd_word[ssdl_pkg::POS_EEE_100TX] = phy_a_adv_ff;
            end
            ssdl_pkg::ADDR_HARDWARE_CONFIG_REG: begin
                rd_word[ssdl_pkg::POS_HW_XOVER] = xover_state_ff;
                rd_word[ssdl_pkg::POS_HW_DONE] = !loading;
            end
            ssdl_pkg::ADDR_PHYB_SCSI: begin
                rd_word[ssdl_pkg::POS_XSEL] = xsel_ff;
                rd_word[ssdl_pkg::POS_XAUTO] = xauto_ff;
                rd_word[ssdl_pkg::POS_XMAN] = xman_ff;
            end
            ssdl_pkg::ADDR_PHYB_BCR: begin
                rd_word[ssdl_pkg::POS_RATE] = rate_ff;
                rd_word[ssdl_pkg::POS_AN] = an_ff;
                rd_word[ssdl_pkg::POS_DUP] = dup_ff;
            end
            ssdl_pkg::ADDR_PHYB_ANADV: begin
                rd_word[ssdl_pkg::POS_ADV_10FD] = adv_10fd_ff;
                rd_word[ssdl_pkg::POS_ADV_10HD] = adv_10hd_ff;
            end
            ssdl_pkg::ADDR_PHYB_SMODE: begin
                rd_word[ssdl_pkg::POS_MODE +: 3] = mode_ff;
            end
            ssdl_pkg::ADDR_STRAP_STAT: begin
                rd_word[7:0] = strap_raw_ff;
            end
            default: begin
                rd_word = ssdl_pkg::RD_ZERO;
            end
        endcase
    end

    // read data captured with the ack so it comes from a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_ff <= ssdl_pkg::RD_ZERO;
        end else if (access && !wb_we_i) begin
            dat_ff <= rd_word;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // ------------------------------------------------------------
    // port 1 and phy a low power defaults
    // ------------------------------------------------------------

    // loaded once, then software owns the writable bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mac_eee_ff <= ssdl_pkg::RST_EEE;
            phy_a_eee_ff <= ssdl_pkg::RST_EEE;
            phy_a_cap_ff <= ssdl_pkg::RST_EEE;
            phy_a_adv_ff <= ssdl_pkg::RST_EEE;
        end else if (loading) begin
            mac_eee_ff <= mac_eee_dflt;
            phy_a_eee_ff <= phy_a_eee_dflt;
            phy_a_cap_ff <= phy_a_eee_dflt;
            phy_a_adv_ff <= phy_a_eee_dflt;
        end else begin
            // capability stays as loaded, it is read only
            mac_eee_ff <= wr_bit(mac_eee_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_MAC_TX_CFG,
                wmask, wb_dat_i, ssdl_pkg::POS_MAC_EEE);
            phy_a_eee_ff <= wr_bit(phy_a_eee_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYA_EDPD,
                wmask, wb_dat_i, ssdl_pkg::POS_PHY_EEE);
            phy_a_adv_ff <= wr_bit(phy_a_adv_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYA_ADV,
                wmask, wb_dat_i, ssdl_pkg::POS_EEE_100TX);
        end
    end

    // ------------------------------------------------------------
    // phy b crossover
    // ------------------------------------------------------------

    // strap state bits are read only; control bits are software's
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xover_state_ff <= ssdl_pkg::RST_AUTO_XOVER;
            man_xover_ff <= ssdl_pkg::RST_MAN_XOVER;
            xsel_ff <= ssdl_pkg::RST_XSEL;
            xauto_ff <= ssdl_pkg::RST_AUTO_XOVER;
            xman_ff <= ssdl_pkg::RST_MAN_XOVER;
        end else if (loading) begin
            xover_state_ff <= auto_xover_dflt;
            man_xover_ff <= man_xover_dflt;
            xsel_ff <= ssdl_pkg::RST_XSEL;
            xauto_ff <= auto_xover_dflt;
            xman_ff <= man_xover_dflt;
        end else begin
            xsel_ff <= wr_bit(xsel_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_SCSI,
                wmask, wb_dat_i, ssdl_pkg::POS_XSEL);
            xauto_ff <= wr_bit(xauto_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_SCSI,
                wmask, wb_dat_i, ssdl_pkg::POS_XAUTO);
            xman_ff <= wr_bit(xman_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_SCSI,
                wmask, wb_dat_i, ssdl_pkg::POS_XMAN);
        end
    end

    // strap select: auto strap wins, else manual strap picks the
    // pair order; register select uses the control bits instead
    always_comb begin
        if (!xsel_ff) begin
            nxt_auto = xover_state_ff;
            nxt_cross = !xover_state_ff && man_xover_ff;
        end else begin
            nxt_auto = xauto_ff;
            nxt_cross = !xauto_ff && xman_ff;
        end
    end

    // crossover outputs registered; both low until loaded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xover_auto_ff <= 1'b0;
            xover_cross_ff <= 1'b0;
        end else begin
            xover_auto_ff <= nxt_auto && !loading;
            xover_cross_ff <= nxt_cross && !loading;
        end
    end

    // ------------------------------------------------------------
    // phy b negotiation, speed and duplex
    // ------------------------------------------------------------

    // basic control bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            an_ff <= ssdl_pkg::RST_AN;
            rate_ff <= ssdl_pkg::RST_SPEED;
            dup_ff <= ssdl_pkg::RST_DUPLEX;
        end else if (loading) begin
            an_ff <= an_dflt;
            rate_ff <= rate_dflt;
            dup_ff <= dup_dflt;
        end else begin
            an_ff <= wr_bit(an_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_BCR,
                wmask, wb_dat_i, ssdl_pkg::POS_AN);
            rate_ff <= wr_bit(rate_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_BCR,
                wmask, wb_dat_i, ssdl_pkg::POS_RATE);
            dup_ff <= wr_bit(dup_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_BCR,
                wmask, wb_dat_i, ssdl_pkg::POS_DUP);
        end
    end

    // advert and mode bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_10fd_ff <= 1'b1;
            adv_10hd_ff <= 1'b1;
            mode_ff <= ssdl_pkg::MODE_ALL_CAPABLE;
        end else if (loading) begin
            adv_10fd_ff <= adv_10fd_dflt;
            adv_10hd_ff <= adv_10hd_dflt;
            mode_ff <= mode_dflt;
        end else begin
            adv_10fd_ff <= wr_bit(adv_10fd_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_ANADV,
                wmask, wb_dat_i, ssdl_pkg::POS_ADV_10FD);
            adv_10hd_ff <= wr_bit(adv_10hd_ff,
                wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_ANADV,
                wmask, wb_dat_i, ssdl_pkg::POS_ADV_10HD);
            if (wr_en && wb_adr_i == ssdl_pkg::ADDR_PHYB_SMODE &&
                wb_sel_i[0]) begin
                mode_ff <= wb_dat_i[ssdl_pkg::POS_MODE +: 3];
            end
        end
    end

    // ------------------------------------------------------------
    // raw strap snapshot
    // ------------------------------------------------------------

    // kept for bring-up: shows levels before fiber masking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_raw_ff <= 8'h00;
        end else if (loading) begin
            strap_raw_ff <= {phy_b_fiber_mode, phy_a_fiber_mode,
                             phy_b_duplex_strap, phy_b_rate_strap,
                             phy_b_negotiation_strap,
                             phy_b_manual_crossover_strap,
                             phy_b_auto_crossover_strap,
                             port1_low_power_ether_strap};
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mac_tx_low_power_enable = mac_eee_ff;
    assign phy_low_power_enable = phy_a_eee_ff;
    assign phy_negotiation_enable = an_ff;
    assign phy_rate_select_lsb = rate_ff;
    assign mode_bit_a = dup_ff;
    assign phy_b_auto_crossover = xover_auto_ff;
    assign phy_b_crossed = xover_cross_ff;
    assign load_done = !loading;

endmodule : ssdl_loader

`default_nettype wire

// ---- rtl/ssdl_pkg.sv ----
package ssdl_pkg;

    // ------------------------------------------------------------
    // register byte offsets (word aligned, classic wishbone)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MAC_TX_CFG = 8'h00; // mac transmit config
    localparam logic [7:0] ADDR_PHYA_EDPD = 8'h04; // phy a energy detect cfg
    localparam logic [7:0] ADDR_PHYA_CAP = 8'h08; // phy a low power capab.
    localparam logic [7:0] ADDR_PHYA_ADV = 8'h0C; // phy a low power advert
    localparam logic [7:0] ADDR_HARDWARE_CONFIG_REG = 8'h10; // hardware config
    localparam logic [7:0] ADDR_PHYB_SCSI = 8'h14; // phy b special ctrl/stat
    localparam logic [7:0] ADDR_PHYB_BCR = 8'h18; // phy b basic control
    localparam logic [7:0] ADDR_PHYB_ANADV = 8'h1C; // phy b negotiation adv.
    localparam logic [7:0] ADDR_PHYB_SMODE = 8'h20; // phy b special modes
    localparam logic [7:0] ADDR_STRAP_STAT = 8'h24; // raw sampled straps

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned POS_MAC_EEE = 0; // mac transmit low power en
    localparam int unsigned POS_PHY_EEE = 0; // phy low power enable
    localparam int unsigned POS_EEE_100TX = 1; // 100base-tx eee cap / adv
    localparam int unsigned POS_HW_XOVER = 0; // crossover strap state
    localparam int unsigned POS_HW_DONE = 1; // strap load finished
    localparam int unsigned POS_XSEL = 15; // 1: registers, 0: straps
    localparam int unsigned POS_XAUTO = 14; // register auto crossover en
    localparam int unsigned POS_XMAN = 13; // register manual crossed
    localparam int unsigned POS_RATE = 13; // rate select lsb
    localparam int unsigned POS_AN = 12; // negotiation enable
    localparam int unsigned POS_DUP = 8; // duplex mode
    localparam int unsigned POS_ADV_10FD = 6; // 10base-t full duplex adv
    localparam int unsigned POS_ADV_10HD = 5; // 10base-t half duplex adv
    localparam int unsigned POS_MODE = 5; // mode field lsb, 3 bits

    // ------------------------------------------------------------
    // strap defaults and values after reset
    // ------------------------------------------------------------
    localparam logic RST_EEE = 1'b0; // pin driven strap, parked low
    localparam logic RST_AUTO_XOVER = 1'b1;
    localparam logic RST_MAN_XOVER = 1'b0;
    localparam logic RST_AN = 1'b1;
    localparam logic RST_SPEED = 1'b1;
    localparam logic RST_DUPLEX = 1'b1;
    localparam logic RST_XSEL = 1'b0; // straps steer crossover
    localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7; // negotiation, all
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // loader sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSDL_LOAD = 2'b01, // first edge after reset release
        SSDL_RUN = 2'b10 // defaults held, bus open
    } ssdl_state_type;

endpackage : ssdl_pkg

// ---- rtl/ssdl_strap_decode.sv ----
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// turns raw strap levels into register defaults
// ------------------------------------------------------------
module ssdl_strap_decode (
    input wire logic eee_strap,
    input wire logic auto_xover_strap,
    input wire logic man_xover_strap,
    input wire logic an_strap,
    input wire logic speed_strap,
    input wire logic duplex_strap,
    input wire logic phy_a_fiber,
    input wire logic phy_b_fiber,
    output logic mac_eee_dflt,
    output logic phy_a_eee_dflt,
    output logic auto_xover_dflt,
    output logic man_xover_dflt,
    output logic an_dflt,
    output logic rate_dflt,
    output logic dup_dflt,
    output logic adv_10fd_dflt,
    output logic adv_10hd_dflt,
    output logic [2:0] mode_dflt
);

    // effective straps once fiber mode has masked them
    logic an_eff; // negotiation strap, forced off on fiber
    logic speed_eff; // speed strap, fiber always runs 100

    // fiber never negotiates eee, so eee stays off there
    assign mac_eee_dflt = eee_strap & ~phy_a_fiber;
    assign phy_a_eee_dflt = eee_strap & ~phy_a_fiber;

    // fiber leaves crossover straps at their plain defaults
    assign auto_xover_dflt = phy_b_fiber ?
                             ssdl_pkg::RST_AUTO_XOVER : auto_xover_strap;
    assign man_xover_dflt = phy_b_fiber ?
                            ssdl_pkg::RST_MAN_XOVER : man_xover_strap;

    assign an_eff = an_strap & ~phy_b_fiber;
    assign speed_eff = speed_strap | phy_b_fiber;

    assign an_dflt = an_eff;
    assign rate_dflt = speed_eff;
    assign dup_dflt = duplex_strap;
    // 10 mb half duplex offered when negotiating or forced to 10; full duplex also needs the duplex strap
    assign adv_10hd_dflt = an_eff | ~speed_eff;
    assign adv_10fd_dflt = (an_eff | ~speed_eff) & duplex_strap;
    // negotiation advertises everything, else forced speed/duplex
    assign mode_dflt = an_eff ? ssdl_pkg::MODE_ALL_CAPABLE :
                       {1'b0, speed_eff, duplex_strap};

endmodule : ssdl_strap_decode

`default_nettype wire

// ---- sim/ssdl_loader_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// strap load and bus answer, seen at the loader ports only
module ssdl_loader_chk (
    input wire logic clk, rst_n, load_done, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic port1_low_power_ether_strap, phy_a_fiber_mode,
    input wire logic phy_b_fiber_mode, phy_b_negotiation_strap,
    input wire logic phy_b_rate_strap, phy_b_duplex_strap,
    input wire logic phy_b_auto_crossover_strap,
    input wire logic phy_b_manual_crossover_strap,
    input wire logic mac_tx_low_power_enable, phy_low_power_enable,
    input wire logic phy_negotiation_enable, phy_rate_select_lsb,
    input wire logic mode_bit_a, phy_b_auto_crossover, phy_b_crossed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // fiber mode masks the straps of its phy
    wire logic eee_x = port1_low_power_ether_strap & ~phy_a_fiber_mode;
    wire logic aut_x = phy_b_auto_crossover_strap | phy_b_fiber_mode;
    wire logic man_x = phy_b_manual_crossover_strap & ~phy_b_fiber_mode;
    sequence s_load;
        $rose(load_done);
    endsequence
    a_mac_eee_load: assert property (
        s_load |-> mac_tx_low_power_enable == eee_x) else $error("mac eee");
    a_phy_eee_load: assert property (
        s_load |-> phy_low_power_enable == eee_x) else $error("phy eee");
    a_neg_load: assert property (s_load |-> phy_negotiation_enable ==
        (phy_b_negotiation_strap & ~phy_b_fiber_mode)) else $error("neg");
    a_rate_load: assert property (s_load |-> phy_rate_select_lsb ==
        (phy_b_rate_strap | phy_b_fiber_mode)) else $error("rate");
    a_dup_load: assert property (
        s_load |-> mode_bit_a == phy_b_duplex_strap) else $error("duplex");
    a_auto_xover: assert property (
        s_load |=> phy_b_auto_crossover == aut_x) else $error("auto xover");
    a_manual_xover: assert property (
        s_load |=> phy_b_crossed == (~aut_x & man_x)) else $error("crossed");
    a_load_held: assert property (load_done |=> load_done)
        else $error("load done dropped");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
        load_done |=> wb_ack_o ##1 !wb_ack_o) else $error("ack late");
    a_no_early_ack: assert property (!load_done |-> !wb_ack_o)
        else $error("ack before load");
endmodule : ssdl_loader_chk
bind ssdl_loader ssdl_loader_chk u_chk (.*);
`default_nettype wire

// ---- sim/ssdl_loader_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssdl_loader_tb_top;
    logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, load_done;
    logic port1_low_power_ether_strap, phy_b_auto_crossover_strap;
    logic phy_b_manual_crossover_strap, phy_b_negotiation_strap;
    logic phy_b_rate_strap, phy_b_duplex_strap, phy_a_fiber_mode;
    logic phy_b_fiber_mode, mac_tx_low_power_enable, phy_low_power_enable;
    logic phy_negotiation_enable, phy_rate_select_lsb, mode_bit_a;
    logic phy_b_auto_crossover, phy_b_crossed;
    logic [7:0] wb_adr_i, st = 8'h00;
    logic [3:0] wb_sel_i = 4'hF, sl;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int err_total, checks_done, seed = 112, man_d, v, lm, mdl[11];
    // writable bits per word; read-only and unmapped words never change
    int wm[11] = '{16'h0001, 16'h0001, 0, 16'h0002, 0, 16'hE000,
        16'h3100, 16'h0060, 16'h00E0, 0, 0};
    assign {phy_b_fiber_mode, phy_a_fiber_mode, phy_b_duplex_strap,
        phy_b_rate_strap, phy_b_negotiation_strap,
        phy_b_manual_crossover_strap, phy_b_auto_crossover_strap,
        port1_low_power_ether_strap} = st;
    ssdl_loader DUT (.*);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // request held until the rising edge that samples ack high; read
    // data is taken at that same edge, only then is the request dropped
    task bus(input logic w, input int i, input logic [31:0] d);
        int n;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= 8'(i * 4);
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk("ack", 32'(n < 20), 1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : bus
    // power-up words worked out from the straps just sampled
    task load_model;
        int e, an, sp, dp, h;
        e = st[0] & ~st[6];
        an = st[3] & ~st[7];
        sp = st[4] | st[7];
        dp = st[5];
        h = an | (1 - sp);
        man_d = st[2] & ~st[7];
        mdl = '{e, e, e * 2, e * 2, (st[1] | st[7]) + 2,
            (st[1] | st[7]) << 14 | man_d << 13, sp << 13 | an << 12 | dp << 8,
            (h & dp) << 6 | h << 5, (an ? 7 : sp * 2 + dp) << 5, st, 0};
    endtask : load_model
    task chk_outs;
        int a;
        a = mdl[5][15] ? mdl[5][14] : mdl[4][0];
        chk("done", 32'(load_done), 1);
        chk("mac", 32'(mac_tx_low_power_enable), mdl[0] & 1);
        chk("phy", 32'(phy_low_power_enable), mdl[1] & 1);
        chk("neg", 32'(phy_negotiation_enable), mdl[6] >> 12 & 1);
        chk("rate", 32'(phy_rate_select_lsb), mdl[6] >> 13 & 1);
        chk("dup", 32'(mode_bit_a), mdl[6] >> 8 & 1);
        chk("auto", 32'(phy_b_auto_crossover), a);
        chk("cross", 32'(phy_b_crossed), (1 - a) &
            (mdl[5][15] ? mdl[5][13] : man_d));
    endtask : chk_outs
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, rst_n} = 4'h0;
        {wb_adr_i, wb_dat_i} = 40'h00_0000_0000;
        // every pass: fresh random straps, reset, read, overwrite, read
        repeat (8) begin
            @(posedge clk);
            rst_n <= 0;
            st <= 8'($random(seed));
            repeat (3) @(posedge clk);
            rst_n <= 1;
            load_model();
            for (int i = 0; i < 11; i++) begin
                bus(0, i, 0);
                chk("rd", rd, mdl[i]);
            end
            chk_outs();
            for (int i = 0; i < 11; i++) begin
                v = $random(seed);
                sl = 4'($random(seed));
                wb_sel_i <= sl;
                bus(1, i, v);
                // only the written byte lanes of writable bits move
                lm = wm[i] & {{8{sl[3]}}, {8{sl[2]}}, {8{sl[1]}}, {8{sl[0]}}};
                mdl[i] = mdl[i] & ~lm | v & lm;
            end
            for (int i = 0; i < 11; i++) begin
                bus(0, i, 0);
                chk("wr", rd, mdl[i]);
            end
            chk_outs();
        end
        wrap_up();
    end
    // hang guard, far beyond the some 820 cycles the passes need
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
endmodule : ssdl_loader_tb_top
`default_nettype wire
